// file: irq_prio_params.svh
`ifndef IRQ_PRIO_PARAMS_SVH
`define IRQ_PRIO_PARAMS_SVH
// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define PRIO_ADDR_EXT 16'hFFF0
`define PRIO_ADDR_TMR12 16'hFFF1
`define PRIO_ADDR_TMR3B 16'hFFF2
`define PRIO_ADDR_SERAD 16'hFFF3
// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define PRIO_RESET 8'h00
`define PRIO_WRITE_MASK 8'h77
`define PRIO_HI_LSB 4
`define PRIO_LO_LSB 0
`define NMI_LEVEL 4'h8
`define NMI_MASK_LOAD 3'h7
// ----------------------------------------------------------------
// vector entries, minimum mode byte address; maximum mode is double
// ----------------------------------------------------------------
`define VEC_NMI 8'h16
`define VEC_EXT0 8'h40
`define VEC_EXT1 8'h42
`define VEC_TMR1 8'h48
`define VEC_TMR2 8'h50
`define VEC_TMR3 8'h58
`define VEC_BYTE 8'h60
`define VEC_SER 8'h68
`define VEC_AD 8'h70
`define VEC_STEP 8'h02
`define VEC_NMI_MAX 9'h02C
`endif

// file: irq_prio_pkg.sv
package irq_prio_pkg;
	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic capture_irq;
		logic compare_a_irq;
		logic compare_b_irq;
		logic wide_timer_overflow_irq;
	} wide_timer_req_s;
	typedef struct packed {
		logic byte_timer_match_a_irq;
		logic byte_timer_match_b_irq;
		logic byte_timer_overflow_irq;
	} byte_timer_req_s;
	typedef struct packed {
		logic serial_error_irq;
		logic serial_receive_irq;
		logic serial_transmit_irq;
	} serial_req_s;
	typedef struct packed {
		logic valid;
		logic [2:0] level;
		logic [7:0] vector;
		logic [4:0] source;
	} candidate_s;
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_decide = 2'b01,
		st_offer = 2'b10
	} resolve_state_e;
endpackage : irq_prio_pkg

// file: module_picker.sv
`timescale 1ns/1ps
`include "irq_prio_params.svh"
// ----------------------------------------------------------------
// picks the first active request of one module, fixed order
// ----------------------------------------------------------------
module module_picker #(
	parameter int N = 4
) (
	// requests, bit N-1 ranks highest
	input wire logic [N-1:0] req_i,
	input wire logic [2:0] level_i,
	input wire logic [7:0] base_i,
	input wire logic [4:0] id_base_i,
	// result
	output irq_prio_pkg::candidate_s cand_o
);
	// highest bit wins; a level of zero never offers
	always_comb begin
		cand_o = '0;
		for (int i = 0; i < N; i++) begin
			if (req_i[i] && level_i != 3'h0) begin
				cand_o.valid = 1'b1;
				cand_o.level = level_i;
				cand_o.vector = base_i +
					8'(N - 1 - i) * `VEC_STEP;
				cand_o.source = id_base_i + 5'(N - 1 - i);
			end
		end
	end
endmodule : module_picker

// file: level_compare.sv
`timescale 1ns/1ps
`include "irq_prio_params.svh"
// ----------------------------------------------------------------
// two-way merge: the higher level wins, ties keep the left one
// ----------------------------------------------------------------
module level_compare (
	// left candidate ranks first on a tie
	input irq_prio_pkg::candidate_s left_i,
	input irq_prio_pkg::candidate_s right_i,
	// winner
	output irq_prio_pkg::candidate_s win_o
);
	// strict greater test keeps the fixed inter-module order
	always_comb begin
		if (right_i.valid && (!left_i.valid ||
			right_i.level > left_i.level)) begin
			win_o = right_i;
		end else begin
			win_o = left_i;
		end
	end
endmodule : level_compare

// file: interrupt_priority_resolver.sv
`timescale 1ns/1ps
`include "irq_prio_params.svh"
module interrupt_priority_resolver (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// register port
	input wire logic [15:0] reg_addr_i,
	input wire logic reg_write_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// request sources
	input wire logic nmi_request_i,
	input wire logic ext_request_0_i,
	input wire logic ext_request_1_i,
	input irq_prio_pkg::wide_timer_req_s timer1_i,
	input irq_prio_pkg::wide_timer_req_s timer2_i,
	input irq_prio_pkg::wide_timer_req_s timer3_i,
	input irq_prio_pkg::byte_timer_req_s byte_timer_i,
	input irq_prio_pkg::serial_req_s serial_interface_i,
	input wire logic conversion_done_irq_i,
	// CPU side
	input wire logic [2:0] cpu_mask_level_i,
	input wire logic max_mode_i,
	input wire logic [31:0] transfer_enable_bit_i,
	input wire logic accept_ack_i,
	// outputs to CPU and transfer controller
	output logic cpu_request_o,
	output logic transfer_controller_start_o,
	output logic [8:0] vector_address_o,
	output logic [3:0] level_o,
	output logic [4:0] source_o
);
	// ----------------------------------------------------------------
	// priority registers
	// ----------------------------------------------------------------
	logic [7:0] prio_ext;
	logic [7:0] prio_tmr12;
	logic [7:0] prio_tmr3b;
	logic [7:0] prio_serad;
	logic [7:0] next_prio_ext;
	logic [7:0] next_prio_tmr12;
	logic [7:0] next_prio_tmr3b;
	logic [7:0] next_prio_serad;
	logic [7:0] next_rdata;
	logic [7:0] wmasked;

	// reserved bits are dropped on write so they always read zero
	always_comb begin
		wmasked = reg_wdata_i & `PRIO_WRITE_MASK;
		next_prio_ext = prio_ext;
		next_prio_tmr12 = prio_tmr12;
		next_prio_tmr3b = prio_tmr3b;
		next_prio_serad = prio_serad;
		if (reg_write_i) begin
			unique case (reg_addr_i)
				`PRIO_ADDR_EXT: next_prio_ext = wmasked;
				`PRIO_ADDR_TMR12: next_prio_tmr12 = wmasked;
				`PRIO_ADDR_TMR3B: next_prio_tmr3b = wmasked;
				`PRIO_ADDR_SERAD: next_prio_serad = wmasked;
				default: next_prio_ext = prio_ext;
			endcase
		end
		unique case (reg_addr_i)
			`PRIO_ADDR_EXT: next_rdata = prio_ext;
			`PRIO_ADDR_TMR12: next_rdata = prio_tmr12;
			`PRIO_ADDR_TMR3B: next_rdata = prio_tmr3b;
			`PRIO_ADDR_SERAD: next_rdata = prio_serad;
			default: next_rdata = 8'h00;
		endcase
	end

	// reset returns every maskable source to level zero
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			prio_ext <= `PRIO_RESET;
			prio_tmr12 <= `PRIO_RESET;
			prio_tmr3b <= `PRIO_RESET;
			prio_serad <= `PRIO_RESET;
			reg_rdata_o <= 8'h00;
		end else begin
			prio_ext <= next_prio_ext;
			prio_tmr12 <= next_prio_tmr12;
			prio_tmr3b <= next_prio_tmr3b;
			prio_serad <= next_prio_serad;
			reg_rdata_o <= next_rdata;
		end
	end

	// upper field in bits 6..4, lower in 2..0, unsigned
	function automatic logic [2:0] hi_field(input logic [7:0] r);
		hi_field = r[`PRIO_HI_LSB +: 3];
	endfunction : hi_field
	function automatic logic [2:0] lo_field(input logic [7:0] r);
		lo_field = r[`PRIO_LO_LSB +: 3];
	endfunction : lo_field

	// ----------------------------------------------------------------
	// per-module candidates
	// ----------------------------------------------------------------
	irq_prio_pkg::candidate_s c_ext0;
	irq_prio_pkg::candidate_s c_ext1;
	irq_prio_pkg::candidate_s c_t1;
	irq_prio_pkg::candidate_s c_t2;
	irq_prio_pkg::candidate_s c_t3;
	irq_prio_pkg::candidate_s c_bt;
	irq_prio_pkg::candidate_s c_ser;
	irq_prio_pkg::candidate_s c_ad;

	// each module's field drives all its requests
	module_picker #(.N(1)) u_ext0 (
		.req_i(ext_request_0_i), .level_i(hi_field(prio_ext)),
		.base_i(`VEC_EXT0), .id_base_i(5'h00),
		.cand_o(c_ext0)
	);
	module_picker #(.N(1)) u_ext1 (
		.req_i(ext_request_1_i), .level_i(lo_field(prio_ext)),
		.base_i(`VEC_EXT1), .id_base_i(5'h01),
		.cand_o(c_ext1)
	);
	module_picker #(.N(4)) u_t1 (
		.req_i(timer1_i), .level_i(hi_field(prio_tmr12)),
		.base_i(`VEC_TMR1), .id_base_i(5'h02),
		.cand_o(c_t1)
	);
	module_picker #(.N(4)) u_t2 (
		.req_i(timer2_i), .level_i(lo_field(prio_tmr12)),
		.base_i(`VEC_TMR2), .id_base_i(5'h06),
		.cand_o(c_t2)
	);
	module_picker #(.N(4)) u_t3 (
		.req_i(timer3_i), .level_i(hi_field(prio_tmr3b)),
		.base_i(`VEC_TMR3), .id_base_i(5'h0A),
		.cand_o(c_t3)
	);
	module_picker #(.N(3)) u_bt (
		.req_i(byte_timer_i), .level_i(lo_field(prio_tmr3b)),
		.base_i(`VEC_BYTE), .id_base_i(5'h0E),
		.cand_o(c_bt)
	);
	module_picker #(.N(3)) u_ser (
		.req_i(serial_interface_i), .level_i(hi_field(prio_serad)),
		.base_i(`VEC_SER), .id_base_i(5'h11),
		.cand_o(c_ser)
	);
	module_picker #(.N(1)) u_ad (
		.req_i(conversion_done_irq_i), .level_i(lo_field(prio_serad)),
		.base_i(`VEC_AD), .id_base_i(5'h14),
		.cand_o(c_ad)
	);

	// ----------------------------------------------------------------
	// tournament, left operand keeps the documented tie order
	// ----------------------------------------------------------------
	irq_prio_pkg::candidate_s w01;
	irq_prio_pkg::candidate_s w23;
	irq_prio_pkg::candidate_s w45;
	irq_prio_pkg::candidate_s w67;
	irq_prio_pkg::candidate_s wa;
	irq_prio_pkg::candidate_s wb;
	irq_prio_pkg::candidate_s winner;
	level_compare u_m01 (.left_i(c_ext0), .right_i(c_ext1), .win_o(w01));
	level_compare u_m23 (.left_i(c_t1), .right_i(c_t2), .win_o(w23));
	level_compare u_m45 (.left_i(c_t3), .right_i(c_bt), .win_o(w45));
	level_compare u_m67 (.left_i(c_ser), .right_i(c_ad), .win_o(w67));
	level_compare u_ma (.left_i(w01), .right_i(w23), .win_o(wa));
	level_compare u_mb (.left_i(w45), .right_i(w67), .win_o(wb));
	level_compare u_mf (.left_i(wa), .right_i(wb), .win_o(winner));

	// ----------------------------------------------------------------
	// two-cycle decision pipeline and handshake
	// ----------------------------------------------------------------
	irq_prio_pkg::resolve_state_e state;
	irq_prio_pkg::resolve_state_e next_state;
	irq_prio_pkg::candidate_s stage;
	irq_prio_pkg::candidate_s next_stage;
	logic nmi_pend;
	logic next_nmi_pend;
	logic next_cpu_req;
	logic next_tc_start;
	logic [8:0] next_vector;
	logic [3:0] next_level;
	logic [4:0] next_source;
	logic above_mask;

	// strictly greater than mask; equal or less stays pending
	assign above_mask = stage.valid &&
		stage.level > cpu_mask_level_i;

	// cycle 1 samples the winner, cycle 2 compares with mask, so a
	// register write can only act after the latency
	always_comb begin
		next_state = state;
		next_stage = stage;
		next_nmi_pend = nmi_pend | nmi_request_i;
		next_cpu_req = cpu_request_o;
		next_tc_start = 1'b0;
		next_vector = vector_address_o;
		next_level = level_o;
		next_source = source_o;
		unique case (state)
			irq_prio_pkg::st_idle: begin
				next_cpu_req = 1'b0;
				if (next_nmi_pend) begin
					// bypasses levels and mask entirely
					next_nmi_pend = 1'b0;
					next_cpu_req = 1'b1;
					next_level = `NMI_LEVEL;
					next_source = 5'h1F;
					next_vector = max_mode_i ? `VEC_NMI_MAX :
						{1'b0, `VEC_NMI};
					next_state = irq_prio_pkg::st_offer;
				end else if (winner.valid) begin
					next_stage = winner;
					next_state = irq_prio_pkg::st_decide;
				end
			end
			irq_prio_pkg::st_decide: begin
				if (above_mask) begin
					next_level = {1'b0, stage.level};
					next_source = stage.source;
					next_vector = max_mode_i ?
						{stage.vector, 1'b0} :
						{1'b0, stage.vector};
					if (transfer_enable_bit_i[stage.source]) begin
						next_tc_start = 1'b1;
						next_state = irq_prio_pkg::st_idle;
					end else begin
						next_cpu_req = 1'b1;
						next_state = irq_prio_pkg::st_offer;
					end
				end else begin
					// source keeps asserting, so retry later
					next_state = irq_prio_pkg::st_idle;
				end
			end
			irq_prio_pkg::st_offer: begin
				if (accept_ack_i) begin
					next_cpu_req = 1'b0;
					next_state = irq_prio_pkg::st_idle;
				end
			end
			default: next_state = irq_prio_pkg::st_idle;
		endcase
	end

	// registers of the decision path; outputs straight from flops
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state <= irq_prio_pkg::st_idle;
			stage <= '0;
			nmi_pend <= 1'b0;
			cpu_request_o <= 1'b0;
			transfer_controller_start_o <= 1'b0;
			vector_address_o <= 9'h000;
			level_o <= 4'h0;
			source_o <= 5'h00;
		end else begin
			state <= next_state;
			stage <= next_stage;
			nmi_pend <= next_nmi_pend;
			cpu_request_o <= next_cpu_req;
			transfer_controller_start_o <= next_tc_start;
			vector_address_o <= next_vector;
			level_o <= next_level;
			source_o <= next_source;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_sampled;
		state == irq_prio_pkg::st_idle && !nmi_pend && !nmi_request_i
			&& winner.valid;
	endsequence
	a_reserved_zero: assert property (@(posedge clock_i)
		disable iff (rst_i) reg_rdata_o[7] == 1'b0 && reg_rdata_o[3] == 1'b0)
		else $error("reserved bit reads one");
	a_reset_clear: assert property (@(posedge clock_i)
		$past(rst_i) |-> prio_ext == 8'h00 && prio_serad == 8'h00)
		else $error("priority not cleared by reset");
	a_two_cycle: assert property (@(posedge clock_i) disable iff (rst_i)
		s_sampled ##1 above_mask && !transfer_enable_bit_i[stage.source]
		|=> cpu_request_o)
		else $error("decision latency wrong");
	a_mask_equal: assert property (@(posedge clock_i) disable iff (rst_i)
		state == irq_prio_pkg::st_decide &&
		stage.level == cpu_mask_level_i |=> !cpu_request_o &&
		!transfer_controller_start_o)
		else $error("equal level accepted");
	a_level_nonzero: assert property (@(posedge clock_i)
		disable iff (rst_i) $rose(cpu_request_o) && level_o != `NMI_LEVEL
		|-> level_o != 4'h0 && level_o > {1'b0, $past(cpu_mask_level_i)})
		else $error("request not above mask");
	a_nmi_bypass: assert property (@(posedge clock_i) disable iff (rst_i)
		state == irq_prio_pkg::st_idle && nmi_request_i |=>
		cpu_request_o && level_o == `NMI_LEVEL)
		else $error("nmi not passed straight");
	a_dtc_start: assert property (@(posedge clock_i) disable iff (rst_i)
		state == irq_prio_pkg::st_decide && above_mask &&
		transfer_enable_bit_i[stage.source] |=>
		transfer_controller_start_o && !cpu_request_o)
		else $error("transfer controller not started");
	a_vector_mode: assert property (@(posedge clock_i)
		disable iff (rst_i)
		state == irq_prio_pkg::st_decide && above_mask && max_mode_i
		|=> vector_address_o[0] == 1'b0 && vector_address_o[1] == 1'b0)
		else $error("max mode vector misaligned");
	a_hold_offer: assert property (@(posedge clock_i) disable iff (rst_i)
		cpu_request_o && !accept_ack_i |=> cpu_request_o &&
		$stable(vector_address_o))
		else $error("offer dropped before ack");
endmodule : interrupt_priority_resolver

// file: cpu_model.sv
`timescale 1ns/1ps
// ------------------------------------------------
// CPU stand-in: takes each offer after a set wait
// ------------------------------------------------
module cpu_model (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// offer and wait setting
	input wire logic cpu_request_i,
	input wire logic [2:0] delay_i,
	// acceptance
	output logic accept_ack_o
);
	logic armed;
	logic [2:0] cnt;
	// one-cycle ack per offer; re-arms only once the offer drops,
	// so an offer still high in the ack cycle is not taken twice
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			armed <= 1'b1;
			cnt <= 3'h0;
			accept_ack_o <= 1'b0;
		end else begin
			accept_ack_o <= 1'b0;
			if (cpu_request_i !== 1'b1) begin
				armed <= 1'b1;
				cnt <= 3'h0;
			end else if (armed && cnt >= delay_i) begin
				accept_ack_o <= 1'b1;
				armed <= 1'b0;
			end else if (armed) begin
				cnt <= cnt + 3'h1;
			end
		end
	end
endmodule : cpu_model

// file: interrupt_priority_resolver_test.sv
`timescale 1ns/1ps
// ------------------------------------------------
// bench: registers, ordering, masking, random mix
// ------------------------------------------------
module interrupt_priority_resolver_test;
	localparam int first_id [0:7] = '{0, 1, 2, 6, 10, 14, 17, 20};
	localparam logic [7:0] vbase [0:7] = '{8'h40, 8'h42, 8'h48, 8'h50,
		8'h58, 8'h60, 8'h68, 8'h70};
	logic clock_i;
	logic rst_i;
	logic [15:0] addr;
	logic wr;
	logic [7:0] wd;
	logic [7:0] rd;
	logic nmi;
	logic [0:20] req;
	logic [2:0] mask;
	logic mx;
	logic [31:0] te;
	logic ack;
	logic creq;
	logic start;
	logic [8:0] vec;
	logic [3:0] lvl;
	logic [2:0] dly;
	logic [4:0] src;
	logic [7:0] prio [0:3];
	int n_fail;
	int tests_run;
	int i;
	int k;
	int w;
	// source vector slices map straight onto the module carriers
	interrupt_priority_resolver dut (.clock_i(clock_i), .rst_i(rst_i),
		.reg_addr_i(addr), .reg_write_i(wr), .reg_wdata_i(wd),
		.reg_rdata_o(rd), .nmi_request_i(nmi), .ext_request_0_i(req[0]),
		.ext_request_1_i(req[1]), .timer1_i(req[2:5]), .timer2_i(req[6:9]),
		.timer3_i(req[10:13]), .byte_timer_i(req[14:16]),
		.serial_interface_i(req[17:19]), .conversion_done_irq_i(req[20]),
		.cpu_mask_level_i(mask), .max_mode_i(mx),
		.transfer_enable_bit_i(te), .accept_ack_i(ack),
		.cpu_request_o(creq), .transfer_controller_start_o(start),
		.vector_address_o(vec), .level_o(lvl), .source_o(src));
	cpu_model partner (.clock_i(clock_i), .rst_i(rst_i),
		.cpu_request_i(creq), .delay_i(dly), .accept_ack_o(ack));
	// free-running 125 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	// software must not lean on a new level sooner, hence the idle edges
	task wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr <= a;
		wr <= 1'b1;
		wd <= d;
		@(posedge clock_i);
		wr <= 1'b0;
		if (a >= 16'hFFF0 && a <= 16'hFFF3) prio[a[1:0]] = d & 8'h77;
		repeat (2) @(posedge clock_i);
	endtask : wr_reg
	task rd_reg(input logic [15:0] a, input logic [7:0] e);
		@(posedge clock_i);
		addr <= a;
		repeat (2) @(posedge clock_i);
		chk(rd, e);
	endtask : rd_reg
	task quiet(input int c);
		int n;
		for (n = 0; n < c; n++) begin
			@(posedge clock_i);
			chk(creq | start, 1'b0);
		end
	endtask : quiet
	function automatic int mod_of(input int id);
		int m;
		m = 7;
		while (id < first_id[m]) m--;
		return m;
	endfunction : mod_of
	function automatic logic [3:0] lv_of(input int id);
		int m;
		m = mod_of(id);
		return m % 2 ? {1'b0, prio[m / 2][2:0]} : {1'b0, prio[m / 2][6:4]};
	endfunction : lv_of
	function automatic logic [8:0] vec_of(input int id, input logic x);
		int m;
		logic [8:0] v;
		if (id == 31) return x ? 9'h02C : 9'h016;
		m = mod_of(id);
		v = {1'b0, vbase[m]} + 9'(2 * (id - first_id[m]));
		return x ? v << 1 : v;
	endfunction : vec_of
	// strict greater keeps the earlier source on a tie
	function automatic int pick();
		int best;
		logic [3:0] b;
		best = 31;
		b = {1'b0, mask};
		for (int id = 0; id < 21; id++) begin
			if (req[id] && lv_of(id) > b) begin
				best = id;
				b = lv_of(id);
			end
		end
		return best;
	endfunction : pick
	// waits for an offer, checks it, then releases the source on accept
	task take(input int id, input logic [3:0] l);
		int n;
		logic got;
		logic ed;
		ed = (id < 21) ? te[id] : 1'b0;
		got = 1'b0;
		for (n = 0; n < 20 && !got; n++) begin
			@(posedge clock_i);
			got = (creq === 1'b1) || (start === 1'b1);
		end
		chk(got, 1'b1);
		if (!got) print_verdict();
		chk(n <= 3, 1'b1);
		chk(src, id[4:0]);
		chk(vec, vec_of(id, mx));
		chk(lvl, l);
		chk(start, ed);
		chk(creq, !ed);
		got = (start === 1'b1);
		for (n = 0; n < 20 && !got; n++) begin
			@(posedge clock_i);
			got = (ack === 1'b1);
		end
		chk(got, 1'b1);
		if (!got) print_verdict();
		if (id < 21) req[id] <= 1'b0;
	endtask : take
	// main sequence
	initial begin
		void'($urandom(32'hBBF6));
		rst_i = 1'b1;
		addr = 16'h0000;
		wr = 1'b0;
		wd = 8'h00;
		nmi = 1'b0;
		req = '0;
		mask = 3'h0;
		mx = 1'b0;
		te = 32'h0;
		dly = 3'h0;
		n_fail = 0;
		tests_run = 0;
		for (i = 0; i < 4; i++) prio[i] = 8'h00;
		repeat (8) @(posedge clock_i);
		rst_i <= 1'b0;
		for (i = 0; i < 4; i++) rd_reg(16'hFFF0 + 16'(i), 8'h00);
		wr_reg(16'hFFF8, 8'hFF);
		rd_reg(16'hFFF8, 8'h00);
		for (i = 0; i < 4; i++) begin
			wr_reg(16'hFFF0 + 16'(i), 8'hFF);
			rd_reg(16'hFFF0 + 16'(i), 8'h77);
			wr_reg(16'hFFF0 + 16'(i), 8'h00);
		end
		// level zero stays masked, then level equal to mask
		@(posedge clock_i);
		mask <= 3'h3;
		req <= '1;
		quiet(8);
		for (i = 0; i < 4; i++) wr_reg(16'hFFF0 + 16'(i), 8'h33);
		quiet(8);
		mask <= 3'h2;
		take(0, 4'h3);
		// one edge apart, so req is not driven twice in one step
		@(posedge clock_i);
		req <= '0;
		repeat (12) @(posedge clock_i);
		// all sources at one level come out in fixed order
		for (i = 0; i < 4; i++) wr_reg(16'hFFF0 + 16'(i), 8'h55);
		req <= '1;
		for (k = 0; k < 21; k++) take(k, 4'h5);
		// nonmaskable with full mask
		mask <= 3'h7;
		nmi <= 1'b1;
		@(posedge clock_i);
		nmi <= 1'b0;
		take(31, 4'h8);
		repeat (12) @(posedge clock_i);
		// random levels, masks, modes and transfer enables
		for (k = 0; k < 40; k++) begin
			for (i = 0; i < 4; i++) wr_reg(16'hFFF0 + 16'(i), 8'($urandom));
			mask <= 3'($urandom);
			mx <= 1'($urandom);
			dly <= 3'($urandom);
			te <= $urandom & 32'h001CDDDF;
			req <= 21'($urandom);
			@(posedge clock_i);
			w = pick();
			if (w == 31) quiet(8);
			else take(w, lv_of(w));
			@(posedge clock_i);
			req <= '0;
			repeat (12) @(posedge clock_i);
		end
		print_verdict();
	end
endmodule : interrupt_priority_resolver_test
